// ==== rtl/sfp_cfg.svh ====
/*
  Constants of the fuse programmer: offsets, fields, levels, keys, timings.
  Assumes a 25 MHz clock and a supply driver following the level code.
*/
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// register byte offsets
`define SFP_OFF_CTRL      8'h00
`define SFP_OFF_STAT      8'h04

// command word fields
`define SFP_CTRL_OP       2:0
`define SFP_CTRL_KEY      7:4
`define SFP_CTRL_VAL      13:8

// status word bits
`define SFP_ST_BUSY       0
`define SFP_ST_DONE       1
`define SFP_ST_FAULT      2
`define SFP_ST_REFUSED    3
`define SFP_ST_LOCKED     4
`define SFP_ST_POWERED    5

// supply level codes
`define SFP_LVL_OFF       2'h0
`define SFP_LVL_LOW       2'h1
`define SFP_LVL_MID       2'h2
`define SFP_LVL_HIGH      2'h3

// keys and codes
`define SFP_KEY_OPER_UP   4'h0
`define SFP_KEY_OPER_DN   4'h1
`define SFP_KEY_CHECK     4'h7
`define SFP_BLOW_KEY      4'h9
`define SFP_LOCK_BIT      6'h03
`define SFP_MAX_BIT       6'h05
`define SFP_CHK_HIGH      6'h0F
`define SFP_CHK_LOW       6'h07

// timings in ns
`define SFP_CLK_NS        40
`define SFP_T_ACTIVE_NS   20000
`define SFP_T_BLOW_NS     100000
`define SFP_T_GAP_NS      20000
`define SFP_T_CHECK_NS    100000
`define SFP_T_SETTLE_NS   1000000
`define SFP_T_PWRUP_NS    1000000
`define SFP_T_OFF_NS      1000000
`define SFP_CYC(ns)       (((ns) + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

`endif

// ==== rtl/sfp_pkg.sv ====
/*
  Types of the supply-pulse fuse programmer: command codes and sequencer
  states. Assumes the constants of sfp_cfg.svh for all encodings.
*/
package sfp_pkg;

  typedef enum logic [2:0] {
    OP_NONE, OP_TRY, OP_BLOW, OP_CHK_LOW, OP_CHK_HIGH, OP_OFF, OP_LOCK
  } sfp_op_t;

  typedef enum {
    S_IDLE, S_PWRUP, S_SEL_H1, S_SEL_M, S_SEL_H2, S_KEY_M, S_KEY_H,
    S_ADDR_M, S_BURN, S_SETTLE, S_CHECK, S_OFF, S_DONE
  } sfp_state_t;

endpackage : sfp_pkg

// ==== rtl/sfp_sync.sv ====
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input is a slow level; glitches shorter than a clock are not filtered.
*/
`timescale 1ns/10ps
module sfp_sync (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // synchronous reset, active low
  input  wire logic d,      // asynchronous level
  output logic      q       // synchronised level
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sfp_sync

// ==== rtl/sfp_pulse.sv ====
/*
  Segment engine: drives lvl for hold cycles, then low for gap cycles, then done.
  Assumes hold >= 1; the level holds its last value when idle.
*/
`timescale 1ns/10ps
`include "sfp_cfg.svh"
module sfp_pulse #(
  parameter int CW = 16
) (
  input  wire logic          clk,    // system clock
  input  wire logic          rst_n,  // synchronous reset, active low
  input  wire logic          go,     // start a segment, taken when idle
  input  wire logic [1:0]    lvl,    // level of the segment
  input  wire logic [CW-1:0] hold,   // cycles at lvl
  input  wire logic [CW-1:0] gap,    // cycles at low level afterwards
  output logic      [1:0]    lvl_q,  // level driven to the supply
  output logic               busy,   // segment in progress
  output logic               done    // one-cycle end mark
);
  logic          gap_ph_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      gap_ph_q <= 1'b0;
      cnt_q    <= '0;
      lvl_q    <= `SFP_LVL_OFF;
    end else begin
      done <= 1'b0;
      if (go && !busy) begin
        busy     <= 1'b1;
        gap_ph_q <= 1'b0;
        lvl_q    <= lvl;
        cnt_q    <= hold - 1'b1;
      end else if (busy) begin
        if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end else if (!gap_ph_q && gap != '0) begin
          // return to the low level, never off: an off would abort the sequence
          gap_ph_q <= 1'b1;
          lvl_q    <= `SFP_LVL_LOW;
          cnt_q    <= gap - 1'b1;
        end else begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : sfp_pulse

// ==== rtl/sfp_top.sv ====
/*
  Fuse programmer: drives a sensor's supply with mid and high pulse
  trains to try codes, blow fuses, lock the part and check fuses;
  software orders it over AXI4-Lite.
  Assumes a supply driver following SUP_LEVEL and a comparator on
  FAULT_CUR for the fault current step.
*/
// Added by the designer: register access over AXI4-Lite and the address map.
// What this block does
// (R1) select register: high, key mid pulses, high
// (R2) device tries by default unless blow key
// (R3) try: each mid pulse raises code one
// (R4) device saturates try code at maximum
// (R5) operate register preloads code one on selection
// (R6) down-counting register inverts the pulse code
// (R7) power cycle discards all trial settings
// (R8) burn order: select, blow key, address, burn
// (R9) blow key: nine mid pulses, one high
// (R10) only one fuse burned per burn pulse
// (R11) blow address is one-hot, one per pulse
// (R12) blow address starts at zero
// (R13) burned bits stay, further bits combine by OR
// (R14) one bit per sequence, power cycle between
// (R15) lock: key 7, blow, four pulses, burn
// (R16) wait settle time after burn before power-off
// (R17) locked device refuses further programming
// (R18) fuse check key 7, try only, always reachable
// (R19) high check burned fuses, low check intact
// (R20) check code 15 high, code 7 low
// (R21) marginal fuse raises supply current
// (R22) pulses qualified by level and width
// (R23) burn only one-hot, unlocked or lock bit
`timescale 1ns/10ps
`include "sfp_cfg.svh"
module sfp_top #(
  parameter int AW           = 8,
  parameter int CW           = 16,
  parameter int T_PWRUP_CYC  = `SFP_CYC(`SFP_T_PWRUP_NS),
  parameter int T_SETTLE_CYC = `SFP_CYC(`SFP_T_SETTLE_NS),
  parameter int T_OFF_CYC    = `SFP_CYC(`SFP_T_OFF_NS)
) (
  input  wire logic          SYS_CLK,        // system clock, 25 MHz
  input  wire logic          RESET_N,        // synchronous reset, active low
  input  wire logic [AW-1:0] S_AXI_AWADDR,   // write address
  input  wire logic          S_AXI_AWVALID,  // write address valid
  output logic               S_AXI_AWREADY,  // write address ready
  input  wire logic [31:0]   S_AXI_WDATA,    // write data
  input  wire logic [3:0]    S_AXI_WSTRB,    // write byte strobes
  input  wire logic          S_AXI_WVALID,   // write data valid
  output logic               S_AXI_WREADY,   // write data ready
  output logic [1:0]         S_AXI_BRESP,    // write response
  output logic               S_AXI_BVALID,   // write response valid
  input  wire logic          S_AXI_BREADY,   // write response ready
  input  wire logic [AW-1:0] S_AXI_ARADDR,   // read address
  input  wire logic          S_AXI_ARVALID,  // read address valid
  output logic               S_AXI_ARREADY,  // read address ready
  output logic [31:0]        S_AXI_RDATA,    // read data
  output logic [1:0]         S_AXI_RRESP,    // read response
  output logic               S_AXI_RVALID,   // read data valid
  input  wire logic          S_AXI_RREADY,   // read data ready
  output logic [1:0]         SUP_LEVEL,      // supply level code to the driver
  input  wire logic          FAULT_CUR       // supply current above fault step
);
  localparam logic [CW-1:0] N_ACTIVE = CW'(`SFP_CYC(`SFP_T_ACTIVE_NS));
  localparam logic [CW-1:0] N_BLOW   = CW'(`SFP_CYC(`SFP_T_BLOW_NS));
  localparam logic [CW-1:0] N_GAP    = CW'(`SFP_CYC(`SFP_T_GAP_NS));
  localparam logic [CW-1:0] N_CHECK  = CW'(`SFP_CYC(`SFP_T_CHECK_NS));
  localparam logic [CW-1:0] N_PWRUP  = CW'(T_PWRUP_CYC);
  localparam logic [CW-1:0] N_SETTLE = CW'(T_SETTLE_CYC);
  localparam logic [CW-1:0] N_OFF    = CW'(T_OFF_CYC);

  if (AW < 3 || CW < 13 || T_PWRUP_CYC < 1 || T_SETTLE_CYC < 1 || T_OFF_CYC < 1 ||
      T_PWRUP_CYC >= 2**CW || T_SETTLE_CYC >= 2**CW || T_OFF_CYC >= 2**CW) begin : g_bad
    $error("sfp_top: parameter out of range");
  end

  // bus slave state
  logic              aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [AW-1:0]     aw_addr_q;
  logic [31:0]       w_data_q, rdata_q;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q, rresp_q;
  // sequencer state
  sfp_pkg::sfp_state_t state_q, state_d;
  sfp_pkg::sfp_op_t    op_q;
  logic [3:0]        key_q;
  logic [5:0]        val_q;
  logic [5:0]        cnt_q, cnt_d;
  logic              done_q, fault_q, refused_q, locked_q;
  logic              fault_s;
  // segment engine
  logic              p_go, p_busy, p_done, need;
  logic [1:0]        p_lvl;
  logic [CW-1:0]     p_hold, p_gap;

  sfp_sync u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .d     (FAULT_CUR),
    .q     (fault_s)
  );

  sfp_pulse #(.CW(CW)) u_pulse (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .go    (p_go),
    .lvl   (p_lvl),
    .hold  (p_hold),
    .gap   (p_gap),
    .lvl_q (SUP_LEVEL),
    .busy  (p_busy),
    .done  (p_done)
  );

  // bus decode
  wire wr_fire  = aw_full_q && w_full_q && !bvalid_q;
  wire wr_word  = w_strb_q[0] && w_strb_q[1];
  wire wr_ctrl  = wr_fire && (aw_addr_q == AW'(`SFP_OFF_CTRL));
  wire wr_stat  = wr_fire && (aw_addr_q == AW'(`SFP_OFF_STAT));
  wire rd_fire  = S_AXI_ARVALID && !rvalid_q;
  wire rd_ctrl  = S_AXI_ARADDR == AW'(`SFP_OFF_CTRL);
  wire rd_stat  = S_AXI_ARADDR == AW'(`SFP_OFF_STAT);
  wire busy     = state_q != sfp_pkg::S_IDLE;
  wire powered  = SUP_LEVEL != `SFP_LVL_OFF;

  assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_full_q && !bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // command decode
  wire [2:0] c_op  = w_data_q[`SFP_CTRL_OP];
  wire [3:0] c_key = w_data_q[`SFP_CTRL_KEY];
  wire [5:0] c_val = w_data_q[`SFP_CTRL_VAL];
  wire c_try   = c_op == sfp_pkg::OP_TRY;
  wire c_blow  = c_op == sfp_pkg::OP_BLOW;
  wire c_check = c_op == sfp_pkg::OP_CHK_LOW || c_op == sfp_pkg::OP_CHK_HIGH;
  wire c_prog  = c_blow || c_op == sfp_pkg::OP_LOCK || (c_try && c_key != `SFP_KEY_CHECK);
  wire c_bad   = c_op == sfp_pkg::OP_NONE || c_op > sfp_pkg::OP_LOCK
                 || (c_blow && c_val > `SFP_MAX_BIT)              // [R10]
                 || (c_try && c_key == `SFP_BLOW_KEY)
                 || (locked_q && c_prog);                         // [R17] [R18]
  wire cmd_ok  = wr_ctrl && wr_word && !busy && !c_bad;
  wire cmd_ref = wr_ctrl && wr_word && (busy || c_bad);
  wire [3:0] n_key = (c_op == sfp_pkg::OP_LOCK || c_check) ? `SFP_KEY_CHECK : c_key;
  wire [5:0] n_val = (c_op == sfp_pkg::OP_LOCK)     ? `SFP_LOCK_BIT :  // [R15]
                     (c_op == sfp_pkg::OP_CHK_HIGH) ? `SFP_CHK_HIGH : // [R19] [R20]
                     (c_op == sfp_pkg::OP_CHK_LOW)  ? `SFP_CHK_LOW  : c_val;

  // operate registers hold code one after selection
  wire preload   = key_q == `SFP_KEY_OPER_UP || key_q == `SFP_KEY_OPER_DN;   // [R5] [R6]
  wire blowing   = op_q == sfp_pkg::OP_BLOW || op_q == sfp_pkg::OP_LOCK;
  wire [5:0] try_n  = (preload && val_q != 6'h00) ? val_q - 6'h01 : val_q;  // [R3] [R4]
  wire [5:0] addr_n = val_q + 6'h01;                                        // [R11] [R12]
  wire lock_burn = key_q == `SFP_KEY_CHECK && val_q == `SFP_LOCK_BIT;

  assign p_go = need && !p_busy && !p_done;

  // sequencer: mid states issue one segment per count of cnt_q, the others at most one; each moves on after its last done
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    need    = 1'b0;
    p_lvl   = `SFP_LVL_LOW;
    p_hold  = N_ACTIVE;
    p_gap   = N_GAP;
    case (state_q)
      sfp_pkg::S_IDLE: begin
        if (cmd_ok) begin
          if (c_op == sfp_pkg::OP_OFF) begin
            state_d = sfp_pkg::S_OFF;
          end else begin
            state_d = powered ? sfp_pkg::S_SEL_H1 : sfp_pkg::S_PWRUP;
          end
        end
      end
      sfp_pkg::S_PWRUP: begin
        need   = 1'b1;
        p_hold = N_PWRUP;
        p_gap  = '0;
        if (p_done) state_d = sfp_pkg::S_SEL_H1;
      end
      sfp_pkg::S_SEL_H1: begin
        need  = 1'b1;                                              // [R1] [R22]
        p_lvl = `SFP_LVL_HIGH;
        if (p_done) begin
          state_d = sfp_pkg::S_SEL_M;
          cnt_d   = {2'b00, key_q};
        end
      end
      sfp_pkg::S_SEL_M: begin
        need  = cnt_q != 6'h00;                                    // [R1]
        p_lvl = `SFP_LVL_MID;
        if (cnt_q == 6'h00) state_d = sfp_pkg::S_SEL_H2;
        else if (p_done) cnt_d = cnt_q - 6'h01;
      end
      sfp_pkg::S_SEL_H2: begin
        need  = 1'b1;
        p_lvl = `SFP_LVL_HIGH;
        if (p_done) begin
          // no blow key means the device stays in try mode
          state_d = blowing ? sfp_pkg::S_KEY_M : sfp_pkg::S_ADDR_M;   // [R2] [R8]
          cnt_d   = blowing ? {2'b00, `SFP_BLOW_KEY} : try_n;
        end
      end
      sfp_pkg::S_KEY_M: begin
        need  = cnt_q != 6'h00;                                    // [R9]
        p_lvl = `SFP_LVL_MID;
        if (cnt_q == 6'h00) state_d = sfp_pkg::S_KEY_H;
        else if (p_done) cnt_d = cnt_q - 6'h01;
      end
      sfp_pkg::S_KEY_H: begin
        need  = 1'b1;                                              // [R9]
        p_lvl = `SFP_LVL_HIGH;
        if (p_done) begin
          state_d = sfp_pkg::S_ADDR_M;
          cnt_d   = addr_n;
        end
      end
      sfp_pkg::S_ADDR_M: begin
        need  = cnt_q != 6'h00;
        p_lvl = `SFP_LVL_MID;
        if (cnt_q == 6'h00) begin
          if (blowing) state_d = sfp_pkg::S_BURN;
          else if (key_q == `SFP_KEY_CHECK) state_d = sfp_pkg::S_CHECK;
          else state_d = sfp_pkg::S_DONE;
        end else if (p_done) begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      sfp_pkg::S_BURN: begin
        need   = 1'b1;                                             // [R8] [R10] [R13] [R23]
        p_lvl  = `SFP_LVL_HIGH;
        p_hold = N_BLOW;
        p_gap  = '0;
        if (p_done) state_d = sfp_pkg::S_SETTLE;
      end
      sfp_pkg::S_SETTLE: begin
        need   = 1'b1;                                             // [R16]
        p_hold = N_SETTLE;
        p_gap  = '0;
        if (p_done) state_d = sfp_pkg::S_OFF;
      end
      sfp_pkg::S_CHECK: begin
        need   = 1'b1;                                             // [R21]
        p_hold = N_CHECK;
        p_gap  = '0;
        if (p_done) state_d = sfp_pkg::S_DONE;
      end
      sfp_pkg::S_OFF: begin
        // every burn ends in a power cycle, so one bit per sequence
        need   = 1'b1;                                             // [R14] [R7]
        p_lvl  = `SFP_LVL_OFF;
        p_hold = N_OFF;
        p_gap  = '0;
        if (p_done) state_d = sfp_pkg::S_DONE;
      end
      sfp_pkg::S_DONE: begin
        state_d = sfp_pkg::S_IDLE;
      end
      default: begin
        state_d = sfp_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_q <= sfp_pkg::S_IDLE;
      cnt_q   <= 6'h00;
      op_q    <= sfp_pkg::OP_NONE;
      key_q   <= 4'h0;
      val_q   <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (cmd_ok) begin
        op_q  <= sfp_pkg::sfp_op_t'(c_op);
        key_q <= n_key;
        val_q <= n_val;
      end
    end
  end

  // sticky done, refused and locked; fault holds the last check result; a set beats a same-cycle clear
  wire st_done  = state_q == sfp_pkg::S_DONE;
  wire clr_done = wr_stat && w_strb_q[0] && w_data_q[`SFP_ST_DONE];
  wire clr_ref  = wr_stat && w_strb_q[0] && w_data_q[`SFP_ST_REFUSED];
  wire chk_end  = state_q == sfp_pkg::S_CHECK && p_done;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      fault_q   <= 1'b0;
      locked_q  <= 1'b0;
    end else begin
      done_q    <= st_done || (done_q && !clr_done);
      refused_q <= cmd_ref || (refused_q && !clr_ref);
      if (chk_end) fault_q <= fault_s;                             // [R21]
      if (state_q == sfp_pkg::S_BURN && p_done && lock_burn) locked_q <= 1'b1;  // [R17]
    end
  end

  wire [31:0] stat_word = {26'h0000000, powered, locked_q, refused_q, fault_q,
                           done_q, busy};
  wire [31:0] ctrl_word = {18'h00000, val_q, key_q, 1'b0, op_q};

  // AXI4-Lite slave: address and data in either order
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bresp_q   <= 2'h0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_ctrl || wr_stat) ? 2'h0 : 2'h2;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_stat ? stat_word : rd_ctrl ? ctrl_word : 32'h00000000;
        rresp_q  <= (rd_stat || rd_ctrl) ? 2'h0 : 2'h2;
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : sfp_top

// ==== verification/sfp_top_props.sv ====
/*
  Checker: bus handshake and supply pulse shape at the top ports.
  Assumes binding into sfp_top.
*/
`timescale 1ns/10ps
module sfp_top_props (
  input wire logic        SYS_CLK,        // system clock
  input wire logic        RESET_N,        // synchronous reset, active low
  input wire logic        S_AXI_AWREADY,  // write address ready
  input wire logic        S_AXI_WREADY,   // write data ready
  input wire logic [1:0]  S_AXI_BRESP,    // write response
  input wire logic        S_AXI_BVALID,   // write response valid
  input wire logic        S_AXI_BREADY,   // write response ready
  input wire logic        S_AXI_ARVALID,  // read address valid
  input wire logic        S_AXI_ARREADY,  // read address ready
  input wire logic [31:0] S_AXI_RDATA,    // read data
  input wire logic        S_AXI_RVALID,   // read data valid
  input wire logic        S_AXI_RREADY,   // read data ready
  input wire logic [1:0]  SUP_LEVEL       // supply level code
);
  logic [1:0]  lvl_q;
  logic [15:0] run_q;

  // run_q holds how long lvl_q stood when the level changes; saturates
  always_ff @(posedge SYS_CLK) begin
    lvl_q <= SUP_LEVEL;
    run_q <= (SUP_LEVEL != lvl_q) ? 16'h0001 : run_q + {15'h0000, run_q != 16'hFFFF};
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_reset_quiet: assert property ($rose(RESET_N) |->
    SUP_LEVEL == 2'h0 && !S_AXI_BVALID && !S_AXI_RVALID) else $error("busy after reset");
  a_bvalid_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken in response");
  a_rvalid_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken in data");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_pulse_width: assert property ((SUP_LEVEL != lvl_q) && lvl_q[1] |-> run_q >= 16'h01F4)
    else $error("pulse too short");
  a_powerup_low: assert property ($past(SUP_LEVEL) == 2'h0 && SUP_LEVEL != 2'h0 |->
    SUP_LEVEL == 2'h1) else $error("pulse without low first");
  a_pulse_to_low: assert property ($past(SUP_LEVEL) >= 2'h2 && SUP_LEVEL != $past(SUP_LEVEL) |->
    SUP_LEVEL <= 2'h1) else $error("no low after pulse");

  c_burn: cover property (lvl_q == 2'h3 && SUP_LEVEL != lvl_q && run_q >= 16'h09C4);
  c_wr_err: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  c_mid: cover property (lvl_q == 2'h2 && SUP_LEVEL == 2'h1);
endmodule : sfp_top_props

bind sfp_top sfp_top_props u_sfp_top_props (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .SUP_LEVEL(SUP_LEVEL));

// ==== verification/sfp_dev_model.sv ====
/*
  Trim-fuse sensor model seen through its supply pin.
  Assumes the programmer's level codes.
*/
`timescale 1ns/10ps
module sfp_dev_model (
  input  wire logic       clk,        // system clock
  input  wire logic [1:0] sup_level,  // supply level code
  input  wire logic       marginal,   // bench asks for a marginal fuse
  output logic            fault_cur,  // fault current step
  output logic [5:0]      try_q,      // applied trial field
  output logic [5:0]      fuse_q,     // blown trim fuses
  output logic            lock_q      // lock fuse blown
);
  logic [1:0] lvl_q  = 2'h0;
  int         run_q  = 0;
  int         stg_q  = 0;
  int         n_q    = 0;
  logic [3:0] key_q  = 4'h0;
  logic [5:0] code_q = 6'h00;
  logic [5:0] addr_q = 6'h00;
  wire        ended  = (sup_level != lvl_q) && (run_q >= 490); // width filter
  wire        burn_ok = $onehot(addr_q) && ((key_q == 4'h7) ? addr_q == 6'h08 : !lock_q);

  assign try_q = (key_q == 4'h1) ? ~code_q : code_q;
  assign fault_cur = marginal && stg_q == 2 && key_q == 4'h7 &&
                     (code_q == 6'h0F || code_q == 6'h07);
  initial begin
    fuse_q = 6'h00;
    lock_q = 1'b0;
  end

  always @(posedge clk) begin
    lvl_q <= sup_level;
    run_q <= (sup_level != lvl_q) ? 1 : run_q + 1;
    if (sup_level == 2'h0) begin // power off forgets trials
      stg_q <= 0;
      key_q <= 4'h0;
      code_q <= 6'h00;
    end else if (ended && lvl_q == 2'h3) begin
      case (stg_q)
        0: stg_q <= 1;
        1: begin // try by default, code one preset for keys 0 and 1
          stg_q <= 2;
          n_q <= 0;
          code_q <= {5'h00, key_q < 4'h2};
        end
        2: begin // nine mids then high: blow
          stg_q <= (n_q == 9) ? 3 : 1;
          addr_q <= 6'h00;
          if (n_q != 9) key_q <= 4'h0;
        end
        3: begin // one fuse per full burn
          if (run_q >= 2250 && burn_ok && key_q == 4'h7) lock_q <= 1'b1;
          if (run_q >= 2250 && burn_ok && key_q != 4'h7) fuse_q <= fuse_q | addr_q;
          stg_q <= 4;
        end
        default: ;
      endcase
    end else if (ended && lvl_q == 2'h2) begin
      if (stg_q == 1) key_q <= key_q + 4'h1;
      if (stg_q == 2) n_q <= n_q + 1;
      if (stg_q == 2 && (!lock_q || key_q == 4'h7) && code_q != 6'h3F) code_q <= code_q + 6'h01;
      if (stg_q == 3) addr_q <= (addr_q == 6'h00) ? 6'h01 : addr_q << 1;
    end
  end
endmodule : sfp_dev_model

// ==== verification/tb_top.sv ====
/*
  Bench: AXI4-Lite tasks issue commands, a device model reads the supply.
  Assumes short power timings set by top parameters.
*/
`timescale 1ns/10ps
`include "sfp_cfg.svh"
module tb_top;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, marginal;
  logic        awready, wready, bvalid, arready, rvalid, fault_cur, lock_v;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, stat_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, sup_level;
  logic [5:0]  try_v, fuse_v;
  int          fails = 0;
  int          tests_run = 0;

  sfp_top #(.T_PWRUP_CYC(20), .T_SETTLE_CYC(20), .T_OFF_CYC(20)) u_sfp_top (
    .SYS_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SUP_LEVEL(sup_level), .FAULT_CUR(fault_cur));
  sfp_dev_model u_sfp_dev_model (.clk(clk), .sup_level(sup_level), .marginal(marginal),
    .fault_cur(fault_cur), .try_q(try_v), .fuse_q(fuse_v), .lock_q(lock_v));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid !== 1'b0 || wvalid !== 1'b0 || bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // polls status, leaving pulse lengths to the design
  task automatic run_cmd(input sfp_pkg::sfp_op_t op, input logic [3:0] key, input logic [5:0] v);
    logic [1:0] r;
    axi_wr(`SFP_OFF_STAT, 32'h0000000A, r);
    axi_wr(`SFP_OFF_CTRL, {18'h00000, v, key, 1'b0, op}, r);
    for (int i = 0; i < 800; i++) begin
      repeat (100) @(posedge clk);
      axi_rd(`SFP_OFF_STAT, stat_v, r);
      if (stat_v[`SFP_ST_DONE] === 1'b1 || stat_v[`SFP_ST_REFUSED] === 1'b1) break;
      if (i == 799) fails++;
    end
  endtask : run_cmd

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    chk("level after reset", 32'h0, 32'(sup_level));
    axi_rd(`SFP_OFF_STAT, d, r);
    chk("status reset", 32'h0, d);
    axi_rd(8'h08, d, r);
    chk("unmapped read resp", 32'h2, 32'(r));
    axi_wr(8'h0C, 32'h00000001, r);
    chk("unmapped write resp", 32'h2, 32'(r));
  endtask : t_bus

  task automatic t_try;
    run_cmd(sfp_pkg::OP_TRY, 4'h0, 6'h02);
    chk("try up field", 32'h02, 32'(try_v));
    chk("try done", 32'h1, 32'(stat_v[`SFP_ST_DONE]));
    chk("powered low", 32'h1, 32'(sup_level));
    run_cmd(sfp_pkg::OP_TRY, 4'h1, 6'h01);
    chk("try down field", 32'h3E, 32'(try_v));
  endtask : t_try

  task automatic t_blow;
    run_cmd(sfp_pkg::OP_BLOW, 4'h0, 6'h02);
    chk("fuse after bit 2", 32'h04, 32'(fuse_v));
    chk("trial after cycle", 32'h00, 32'(try_v));
    run_cmd(sfp_pkg::OP_BLOW, 4'h0, 6'h00);
    chk("fuse after bit 0", 32'h05, 32'(fuse_v));
  endtask : t_blow

  task automatic t_lock;
    run_cmd(sfp_pkg::OP_LOCK, 4'h7, 6'h03);
    chk("lock fuse", 32'h1, 32'(lock_v));
    chk("locked flag", 32'h1, 32'(stat_v[`SFP_ST_LOCKED]));
    run_cmd(sfp_pkg::OP_BLOW, 4'h0, 6'h01);
    chk("refused after lock", 32'h1, 32'(stat_v[`SFP_ST_REFUSED]));
    chk("fuse kept", 32'h05, 32'(fuse_v));
  endtask : t_lock

  task automatic t_check;
    marginal <= 1'b1;
    run_cmd(sfp_pkg::OP_CHK_HIGH, 4'h7, 6'h0F);
    chk("check code", 32'h0F, 32'(try_v));
    chk("fault flag", 32'h1, 32'(stat_v[`SFP_ST_FAULT]));
    run_cmd(sfp_pkg::OP_OFF, 4'h0, 6'h00);
    chk("off level", 32'h0, 32'(sup_level));
  endtask : t_check

  task automatic summarize;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, marginal} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h00000000, 4'hF};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_bus();
    t_try();
    t_blow();
    t_lock();
    t_check();
    summarize();
  end

  initial begin
    repeat (99000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : tb_top
